// ### cis_pkg.sv
/*
  Shared constants and types for the charger serial register target and its bus master.
  Assumes both ends import it whole and that the link wires meet in cis_link_if.
*/
// How it works
// - Target only pulls data low; clock input.
// - Bytes travel most significant bit first.
// - Answer only to target address 1101011.
// - Sample on clock rise; change data low.
// - Start is data falling while clock high.
// - Stop is data rising; return to idle.
// - Read: address, pointer, repeated start, address.
// - Master code 00001xxx is never acknowledged.
// - Repeated start after code enters high speed.
// - High speed packets split by repeated starts.
// - Acknowledge own address and each later received byte on ninth clock.
// - Commit written byte at eighth falling edge.
// - Pointer advances after each written byte.
// - Master acknowledge advances read; nack ends.
// - Monitor registers show live undebounced status.
`default_nettype none

package cis_pkg;

  // ---------------------------------------------------------------
  // Addressing
  // ---------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h6b;
  localparam logic       DIR_WRITE   = 1'h0;
  localparam logic       DIR_READ    = 1'h1;
  localparam logic [4:0] MCODE_TOP   = 5'h01;
  localparam logic [7:0] MCODE_BYTE  = 8'h08;

  // ---------------------------------------------------------------
  // Target register file
  // ---------------------------------------------------------------
  localparam int         REG_COUNT   = 8;
  localparam logic [7:0] MON_A_OFS   = 8'h10;
  localparam logic [7:0] MON_B_OFS   = 8'h11;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [2:0] BYTE_MSB    = 3'h7;

  // ---------------------------------------------------------------
  // Master command port
  // ---------------------------------------------------------------
  localparam logic [2:0] HR_PTR      = 3'h0;
  localparam logic [2:0] HR_WDATA    = 3'h1;
  localparam logic [2:0] HR_CMD      = 3'h2;
  localparam logic [2:0] HR_STATUS   = 3'h3;
  localparam logic [2:0] HR_RDATA    = 3'h4;
  localparam int         CMD_GO_BIT  = 0;
  localparam int         CMD_RD_BIT  = 1;
  localparam int         CMD_HS_BIT  = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_NS      = 10;
  localparam int         SCL_QTR_NS  = 625;
  localparam logic [7:0] QTR_CYC     = 8'(SCL_QTR_NS / CLK_NS);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'h0,
    ST_RX     = 3'h1,
    ST_RX_ACK = 3'h3,
    ST_TX     = 3'h2,
    ST_TX_ACK = 3'h6,
    ST_WAIT   = 3'h7
  } cis_state_e;

  typedef enum logic [1:0]
  {
    ROLE_ADDR = 2'h0,
    ROLE_PTR  = 2'h1,
    ROLE_DATA = 2'h3
  } cis_role_e;

  typedef enum logic [2:0]
  {
    OP_START = 3'h0,
    OP_TX    = 3'h1,
    OP_RX    = 3'h3,
    OP_STOP  = 3'h2,
    OP_END   = 3'h6
  } cis_op_e;

  localparam logic [3:0] STEP_FIRST  = 4'h0;
  localparam logic [3:0] STEP_MCODE  = 4'h1;
  localparam logic [3:0] STEP_PLAIN  = 4'h2;

endpackage : cis_pkg

`default_nettype wire

// ### cis_link_if.sv
/*
  The two-wire link between the bus master and the charger register target.
  Assumes a pull-up on both lines and a bench that drives the target's link clock.
*/
`default_nettype none

interface cis_link_if
(
  input wire logic link_clk
);

  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wired AND: any enable pulls the line low.
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host
  (
    output host_scl_oe,
    output host_sda_oe,
    input  sda
  );

  modport device
  (
    input  link_clk,
    input  scl,
    input  sda,
    output dev_sda_oe
  );

endinterface : cis_link_if

`default_nettype wire

// ### cis_sync.sv
/*
  Two-flop level synchroniser, one lane per bit.
  Assumes its inputs come from another clock domain or a pin.
*/
`default_nettype none

module cis_sync
#(
  parameter int         WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Levels
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= INIT;
      q_o      <= INIT;
    end
    else
    begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule : cis_sync

`default_nettype wire

// ### cis_device.sv
/*
  Charger register target: decodes the two-wire link and serves its byte registers.
  Assumes link_clk oversamples the bus clock by at least eight, and rst_b_i is synchronous to it.
*/
`default_nettype none

module cis_device
  import cis_pkg::*;
(
  // Link
  cis_link_if.device                link,
  // Reset, synchronous to the link clock
  input  wire logic                 rst_b_i,
  // Live monitor status
  input  wire logic [7:0]           status_a_i,
  input  wire logic [7:0]           status_b_i,
  // Register contents and write events
  output logic      [REG_COUNT*8-1:0] ctrl_regs_o,
  output logic                      wr_pulse_o,
  output logic      [7:0]           wr_addr_o,
  output logic      [7:0]           wr_data_o,
  output logic                      hs_mode_o
);

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [1:0]  pin_s;
  logic [1:0]  pin_q_reg;
  logic [15:0] status_s;

  // Bus clock is an input only; both lines pass two flops first.
  // clock only sampled
  cis_sync #(.WIDTH(2), .INIT(2'h3)) u_pin_sync
  (
    .clock_i (link.link_clk),
    .rst_b_i (rst_b_i),
    .d_i     ({link.scl, link.sda}),
    .q_o     (pin_s)
  );

  // Monitor bits are only synchronised, never filtered.
  // no debounce applied
  cis_sync #(.WIDTH(16), .INIT(16'h0000)) u_status_sync
  (
    .clock_i (link.link_clk),
    .rst_b_i (rst_b_i),
    .d_i     ({status_b_i, status_a_i}),
    .q_o     (status_s)
  );

  // One more stage of history for edge detection.
  always_ff @(posedge link.link_clk)
  begin
    if (!rst_b_i)
      pin_q_reg <= 2'h3;
    else
      pin_q_reg <= pin_s;
  end

  // Bit 1 is the clock line and bit 0 the data line.
  wire scl_now   = pin_s[1];
  wire sda_now   = pin_s[0];
  wire scl_rise  = scl_now & ~pin_q_reg[1];
  wire scl_fall  = ~scl_now & pin_q_reg[1];
  wire start_det = scl_now & pin_q_reg[1] & pin_q_reg[0] & ~sda_now;
  wire stop_det  = scl_now & pin_q_reg[1] & ~pin_q_reg[0] & sda_now;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cis_state_e state_reg, state_next;
  cis_role_e  role_reg, role_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       read_reg, read_next;
  logic       acked_reg, acked_next;
  logic       sda_oe_reg, sda_oe_next;
  logic       hs_pend_reg, hs_pend_next;
  logic       hs_reg, hs_next;
  logic       wr_next;
  logic [7:0] wr_addr_next, wr_data_next;
  logic [7:0] regs [REG_COUNT];

  // ---------------------------------------------------------------
  // Read selection
  // ---------------------------------------------------------------
  wire        ptr_in_file = (ptr_reg < 8'(REG_COUNT));
  wire        ptr_mon_a   = (ptr_reg == MON_A_OFS);
  wire        ptr_mon_b   = (ptr_reg == MON_B_OFS);
  wire  [7:0] file_byte   = regs[ptr_reg[2:0]];
  wire  [7:0] rd_byte     = ptr_in_file ? file_byte :
                            ptr_mon_a   ? status_s[7:0] :
                            ptr_mon_b   ? status_s[15:8] : 8'h00;
  wire        addr_match  = (shift_reg[7:1] == TARGET_ADDR);
  wire        mcode_seen  = (shift_reg[7:3] == MCODE_TOP);

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  // A stop or start overrides whatever byte is in flight.
  always_comb
  begin
    state_next   = state_reg;
    role_next    = role_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    read_next    = read_reg;
    acked_next   = acked_reg;
    sda_oe_next  = sda_oe_reg;
    hs_pend_next = hs_pend_reg;
    hs_next      = hs_reg;
    wr_next      = 1'b0;
    wr_addr_next = wr_addr_o;
    wr_data_next = wr_data_o;
    if (stop_det)
    begin
      state_next   = ST_IDLE;
      sda_oe_next  = 1'b0;
      hs_next      = 1'b0;
      hs_pend_next = 1'b0;
    end
    else if (start_det)
    begin
      state_next   = ST_RX;
      role_next    = ROLE_ADDR;
      cnt_next     = 4'h0;
      sda_oe_next  = 1'b0;
      hs_next      = hs_reg | hs_pend_reg;
      hs_pend_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RX:
        begin
          if (scl_rise && cnt_reg != BYTE_BITS)
          begin
            // first bit lands in bit seven
            shift_next = {shift_reg[6:0], sda_now};
            cnt_next   = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == BYTE_BITS)
          begin
            cnt_next = 4'h0;
            case (role_reg)
              ROLE_ADDR:
              begin
                if (addr_match)
                begin
                  sda_oe_next = 1'b1;
                  read_next   = shift_reg[0];
                  state_next  = ST_RX_ACK;
                end
                else
                begin
                  hs_pend_next = mcode_seen;
                  state_next   = ST_WAIT;
                end
              end
              ROLE_PTR:
              begin
                ptr_next    = shift_reg;
                sda_oe_next = 1'b1;
                state_next  = ST_RX_ACK;
              end
              default:
              begin
                wr_next      = 1'b1;
                wr_addr_next = ptr_reg;
                wr_data_next = shift_reg;
                ptr_next     = ptr_reg + 8'h01;
                sda_oe_next  = 1'b1;
                state_next   = ST_RX_ACK;
              end
            endcase
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            if (role_reg == ROLE_ADDR && read_reg == DIR_READ)
            begin
              shift_next  = rd_byte;
              sda_oe_next = ~rd_byte[7];
              cnt_next    = 4'h0;
              state_next  = ST_TX;
            end
            else
            begin
              sda_oe_next = 1'b0;
              role_next   = (role_reg == ROLE_ADDR) ? ROLE_PTR : ROLE_DATA;
              state_next  = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == BIT_LAST)
            begin
              sda_oe_next = 1'b0;
              state_next  = ST_TX_ACK;
            end
            else
            begin
              shift_next  = {shift_reg[6:0], 1'b0};
              sda_oe_next = ~shift_reg[6];
              cnt_next    = cnt_reg + 4'h1;
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            acked_next = ~sda_now;
            if (!sda_now)
              ptr_next = ptr_reg + 8'h01;
          end
          else if (scl_fall)
          begin
            if (acked_reg)
            begin
              shift_next  = rd_byte;
              sda_oe_next = ~rd_byte[7];
              cnt_next    = 4'h0;
              state_next  = ST_TX;
            end
            else
            begin
              state_next = ST_WAIT;
            end
          end
        end
        default:
        begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // Engine registers.
  always_ff @(posedge link.link_clk)
  begin
    if (!rst_b_i)
    begin
      state_reg   <= ST_IDLE;
      role_reg    <= ROLE_ADDR;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      read_reg    <= DIR_WRITE;
      acked_reg   <= 1'b0;
      sda_oe_reg  <= 1'b0;
      hs_pend_reg <= 1'b0;
      hs_reg      <= 1'b0;
      wr_pulse_o  <= 1'b0;
      wr_addr_o   <= 8'h00;
      wr_data_o   <= 8'h00;
    end
    else
    begin
      state_reg   <= state_next;
      role_reg    <= role_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      read_reg    <= read_next;
      acked_reg   <= acked_next;
      sda_oe_reg  <= sda_oe_next;
      hs_pend_reg <= hs_pend_next;
      hs_reg      <= hs_next;
      wr_pulse_o  <= wr_next;
      wr_addr_o   <= wr_addr_next;
      wr_data_o   <= wr_data_next;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Writes land two cycles after the eighth fall is seen; monitor and unmapped writes are dropped.
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++)
    begin : g_reg
      always_ff @(posedge link.link_clk)
      begin
        if (!rst_b_i)
          regs[gi] <= REG_RESET;
        else if (wr_pulse_o && wr_addr_o == 8'(gi))
          regs[gi] <= wr_data_o;
      end
      assign ctrl_regs_o[gi*8 +: 8] = regs[gi];
    end
  endgenerate

  assign link.dev_sda_oe = sda_oe_reg;
  assign hs_mode_o       = hs_reg;

endmodule : cis_device

`default_nettype wire

// ### cis_host.sv
/*
  Bus master for the charger target: single-byte write or read, optionally after a high-speed master code.
  Assumes software on clock_i drives the command port; the target's data line is asynchronous here.
*/
`default_nettype none

module cis_host
  import cis_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // Command port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Link
  cis_link_if.host        link
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] ptr_reg, wdata_reg, rx_reg, shift_reg, qcnt_reg;
  logic       read_reg, busy_reg, nack_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg, step_reg;
  logic       scl_oe_reg, sda_oe_reg;
  logic       sda_s;

  // Data line from the target passes two flops.
  cis_sync #(.WIDTH(1), .INIT(1'h1)) u_sda_sync
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .d_i     (link.sda),
    .q_o     (sda_s)
  );

  // ---------------------------------------------------------------
  // Sequence table
  // ---------------------------------------------------------------
  // write address, pointer, repeated start, read address
  function automatic logic [10:0] step_op(input logic [3:0] s, input logic rd);
    case (s)
      4'h0:    step_op = {OP_START, 8'h00};
      4'h1:    step_op = {OP_TX, MCODE_BYTE};
      4'h2:    step_op = {OP_START, 8'h00};
      4'h3:    step_op = {OP_TX, TARGET_ADDR, DIR_WRITE};
      4'h4:    step_op = {OP_TX, ptr_reg};
      4'h5:    step_op = rd ? {OP_START, 8'h00} : {OP_TX, wdata_reg};
      4'h6:    step_op = rd ? {OP_TX, TARGET_ADDR, DIR_READ} : {OP_STOP, 8'h00};
      4'h7:    step_op = rd ? {OP_RX, 8'h00} : {OP_END, 8'h00};
      4'h8:    step_op = rd ? {OP_STOP, 8'h00} : {OP_END, 8'h00};
      default: step_op = {OP_END, 8'h00};
    endcase
  endfunction : step_op

  wire [10:0] cur      = step_op(step_reg, read_reg);
  wire [2:0]  cur_op   = cur[10:8];
  wire [7:0]  cur_byte = cur[7:0];
  wire        tx_bit   = cur_byte[3'(BYTE_MSB - bit_reg[2:0])];
  wire        data_bit = (bit_reg != BYTE_BITS);
  wire        tick     = busy_reg && (qcnt_reg == QTR_CYC);
  wire        go       = wr_i && (addr_i == HR_CMD) && wdata_i[CMD_GO_BIT] && !busy_reg;

  // ---------------------------------------------------------------
  // Command registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      ptr_reg   <= 8'h00;
      wdata_reg <= 8'h00;
      read_reg  <= 1'b0;
    end
    else if (wr_i && !busy_reg)
    begin
      if (addr_i == HR_PTR)
        ptr_reg <= wdata_i;
      if (addr_i == HR_WDATA)
        wdata_reg <= wdata_i;
      if (go)
      begin
        read_reg <= wdata_i[CMD_RD_BIT];
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  wire [7:0] rd_mux = (addr_i == HR_PTR)    ? ptr_reg :
                      (addr_i == HR_WDATA)  ? wdata_reg :
                      (addr_i == HR_STATUS) ? {6'h00, nack_reg, busy_reg} :
                      (addr_i == HR_RDATA)  ? rx_reg : 8'h00;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? rd_mux : 8'h00;
  end

  // ---------------------------------------------------------------
  // Bit engine: four quarter phases per bit, clock high in phases 2 and 3
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      busy_reg   <= 1'b0;
      nack_reg   <= 1'b0;
      qcnt_reg   <= 8'h00;
      phase_reg  <= 2'h0;
      bit_reg    <= 4'h0;
      step_reg   <= STEP_FIRST;
      shift_reg  <= 8'h00;
      rx_reg     <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (go)
    begin
      busy_reg  <= 1'b1;
      nack_reg  <= 1'b0;
      qcnt_reg  <= 8'h00;
      phase_reg <= 2'h0;
      bit_reg   <= 4'h0;
      step_reg  <= wdata_i[CMD_HS_BIT] ? STEP_FIRST : STEP_PLAIN;
    end
    else if (busy_reg)
    begin
      qcnt_reg <= tick ? 8'h00 : qcnt_reg + 8'h01;
      if (tick)
      begin
        phase_reg <= phase_reg + 2'h1;
        case (phase_reg)
          2'h0:
          begin
            // data changes with clock low
            // The end step leaves the clock released, so the bus idles with both lines high.
            if (cur_op != OP_END)
              scl_oe_reg <= 1'b1;
            sda_oe_reg <= (cur_op == OP_STOP) | (cur_op == OP_TX && data_bit && !tx_bit);
            if (cur_op == OP_END)
              busy_reg <= 1'b0;
          end
          2'h1: scl_oe_reg <= 1'b0;
          2'h2:
          begin
            if (cur_op == OP_START)
              sda_oe_reg <= 1'b1;
            if (cur_op == OP_STOP)
              sda_oe_reg <= 1'b0;
            if (cur_op == OP_TX && !data_bit && sda_s && step_reg != STEP_MCODE)
              nack_reg <= 1'b1;
            if (cur_op == OP_RX && data_bit)
              shift_reg <= {shift_reg[6:0], sda_s};
          end
          default:
          begin
            if (cur_op == OP_TX || cur_op == OP_RX)
            begin
              scl_oe_reg <= 1'b1;
              bit_reg    <= data_bit ? bit_reg + 4'h1 : 4'h0;
              if (!data_bit)
                step_reg <= step_reg + 4'h1;
              if (!data_bit && cur_op == OP_RX)
                rx_reg <= shift_reg;
            end
            else
            begin
              // start after code is a repeated start
              scl_oe_reg <= (cur_op == OP_START);
              step_reg   <= step_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end

  assign link.host_scl_oe = scl_oe_reg;
  assign link.host_sda_oe = sda_oe_reg;

endmodule : cis_host

`default_nettype wire

// ### cis_monitor.sv
/*
  Wire checker for the two-wire link.
  Assumes the link signals and the target reset as inputs.
*/
`default_nettype none
module cis_monitor
  import cis_pkg::*;
(
  // Link clock, target reset and wires
  input wire logic link_clk,
  input wire logic rst_b_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic       wa;
  logic       ra;
  logic [7:0] sh;
  logic [3:0] n;
  wire logic  rise = scl & ~scl_q;
  wire logic  st   = scl & scl_q & sda_q & ~sda;
  wire logic  sp   = scl & scl_q & ~sda_q & sda;
  wire logic  ack9 = rise & (n == 4'h8);
  // Bits since the last start or ninth clock; raw wires, so read data is seen too.
  always_ff @(posedge link_clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_b_i | st | sp)
    begin
      n     <= 4'h0;
      first <= rst_b_i & st;
      wa    <= 1'b0;
      ra    <= 1'b0;
    end
    else if (rise)
    begin
      sh <= {sh[6:0], sda};
      n  <= ack9 ? 4'h0 : n + 4'h1;
      if (ack9)
        first <= 1'b0;
      if (ack9 & first)
        wa <= (sh == {TARGET_ADDR, DIR_WRITE});
      if (ack9 & first)
        ra <= (sh == {TARGET_ADDR, DIR_READ});
    end
  end
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_b_i);
  own_addr_a:
    assert property (ack9 && first && sh[7:1] == TARGET_ADDR |-> !sda)
    else $error("own address not acknowledged");
  foreign_code_a:
    assert property (ack9 && first && sh[7:1] != TARGET_ADDR |-> sda)
    else $error("foreign byte acknowledged");
  addr_quiet_a:
    assert property (rise && first && n < 4'h8 |-> !dev_sda_oe)
    else $error("target drove during address bits");
  hold_high_a:
    assert property (scl && scl_q |-> $stable(dev_sda_oe))
    else $error("target changed data while clock high");
  start_quiet_a:
    assert property (st |-> !dev_sda_oe [*8])
    else $error("target drove after start");
  stop_idle_a:
    assert property (sp |-> !dev_sda_oe [*8])
    else $error("target not idle after stop");
  write_ack_a:
    assert property (ack9 && wa |-> !sda)
    else $error("written byte not acknowledged");
  read_release_a:
    assert property (ack9 && ra |-> !dev_sda_oe)
    else $error("target held data in master ack slot");
endmodule : cis_monitor
`default_nettype wire

// ### tb_charger_i2c_register_slave.sv
/*
  Bench: host and target joined over the link, driven by port commands.
  Assumes both ends are design code meeting in cis_link_if.
*/
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module tb_charger_i2c_register_slave;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 0, lclk = 0, rst_b = 0, drst_b = 0, wr = 0, rd = 0, hs, hs_seen = 0, wp;
  logic [2:0]  addr = 0;
  logic [7:0]  wdata = 0, rdata, rdv, wa, wd, sa = 8'h5a, sb = 8'hc3;
  logic [7:0]  pt [5] = '{8'h03, 8'h07, 8'h10, 8'h11, 8'h20};
  logic [7:0]  ex [5] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h00};
  logic [63:0] regs;
  int          fails = 0, samples_checked = 0, k, wr_cnt = 0;
  // Clocks: the link clock has an odd offset so its edges never line up with clock_i edges.
  always #5 clock_i = ~clock_i;
  initial #33 forever #80 lclk = ~lclk;
  cis_link_if lk (.link_clk(lclk));
  cis_host cis_host_inst (.clock_i(clock_i), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(lk));
  cis_device cis_device_inst (.link(lk), .rst_b_i(drst_b), .status_a_i(sa), .status_b_i(sb),
    .ctrl_regs_o(regs), .wr_pulse_o(wp), .wr_addr_o(wa), .wr_data_o(wd), .hs_mode_o(hs));
  cis_monitor cis_monitor_inst (.link_clk(lclk), .rst_b_i(drst_b), .scl(lk.scl), .sda(lk.sda),
    .dev_sda_oe(lk.dev_sda_oe));
  always @(posedge lclk) if (hs) hs_seen <= 1'b1;
  // Counts committed write strobes; reads must never raise one.
  always @(posedge lclk) if (wp) wr_cnt <= wr_cnt + 1;
  task put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clock_i) wr <= 1'b0;
  endtask : put
  task rdr(input logic [2:0] a);
    @(posedge clock_i) {addr, rd} <= {a, 1'b1};
    @(posedge clock_i) rd <= 1'b0;
    #1 rdv = rdata;
  endtask : rdr
  // One transfer; polling is bounded because a hung link must not hang the run.
  task xfer(input logic [7:0] p, input logic [7:0] d, input logic [7:0] c);
    put(3'h0, p);
    put(3'h1, d);
    put(3'h2, c);
    k = 0;
    do begin rdr(3'h3); k++; end while (rdv[0] !== 1'b0 && k < 9000);
    `CHK(rdv[1:0], 2'h0)
    repeat (100) @(posedge clock_i);
  endtask : xfer
  task give_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin repeat (4) @(posedge lclk); drst_b <= 1'b1; end
  initial begin #1ms; fails++; give_verdict(); end
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_b <= 1'b1;
    repeat (100) @(posedge clock_i);
    xfer(8'h03, 8'ha5, 8'h01);
    `CHK(regs, 64'h0000_0000_a500_0000)
    `CHK({wa, wd}, 16'h03a5)
    xfer(8'h07, 8'h3c, 8'h05);
    `CHK(hs_seen, 1'b1)
    `CHK(hs, 1'b0)
    `CHK(regs, 64'h3c00_0000_a500_0000)
    xfer(8'h11, 8'hff, 8'h01);
    `CHK(wr_cnt, 3)
    for (int i = 0; i < 5; i++)
    begin
      xfer(pt[i], 8'h00, 8'h03);
      rdr(3'h4);
      `CHK(rdv, ex[i])
    end
    `CHK(wr_cnt, 3)
    @(posedge clock_i) sa <= 8'h96;
    xfer(8'h10, 8'h00, 8'h03);
    rdr(3'h4);
    `CHK(rdv, 8'h96)
    rdr(3'h7);
    `CHK(rdv, 8'h00)
    give_verdict();
  end
endmodule : tb_charger_i2c_register_slave
`default_nettype wire
